/* File: design/pmd_pkg.sv */
// package: constants and carrier types for the panel meter display and serial front
// -----------------------------------------------------------------------------
// Summary of operation
// - negatives up to three digits: steady minus in left digit, magnitude right
// - four-digit negatives alternate minus alone and four magnitude digits
// - input above range: overload legend with flashing overscores
// - bipolar input below range: overload legend with flashing underscores
// - display value above +9999: overscore overload legend, flashing
// - display value below -9999: underscore overload legend, flashing
// - current loop below 3.8 mA: underscore overload legend, broken wire
// - display intensity has eight levels
// - bit rates 1200 to 115.2k (code 0 gives a 17797-cycle bit, about 5619 baud, not 1200); parity none, even, odd, mark, space
// - every character has eight data bits and one stop bit
// - mark parity sends parity bit at stop level, like two stop bits
// - transmit only in reply to a host command, never spontaneously
// - with addressing on, reply only when address byte matches own address
// - matching command briefly lights right decimal point; bursts give flashes
// - addressing off: every received command flashes the dot, valid or not
// - a setting enables or suppresses the command indicator dot
// - listen-only state keeps dot lit steadily, overriding the disable
// - listen-only: no replies, only the leaving function 8 command acts
// - unit addresses 0xf8 to 0xff disable addressing
// -----------------------------------------------------------------------------
package pmd_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned BLINK_HALF_MS = 250;
    localparam int unsigned BLINK_HALF_CYC = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int unsigned DOT_MS = 30;
    localparam int unsigned DOT_CYC = CLK_HZ / 1000 * DOT_MS;
    localparam int unsigned PWM_STEPS = 8;
    localparam logic [13:0] MAG_MAX = 14'h270f;
    localparam logic [13:0] MAG_3DIG = 14'h03e7;
    localparam logic [7:0] ADDR_OFF_MIN = 8'hf8;
    localparam logic [3:0] SEG_BLANK = 4'ha;
    localparam logic [3:0] SEG_MINUS = 4'hb;
    localparam logic [3:0] SEG_O = 4'hc;
    localparam logic [3:0] SEG_L = 4'hd;
    localparam logic [3:0] SEG_OVER = 4'he;
    localparam logic [3:0] SEG_UNDER = 4'hf;
    // bit-rate codes 0..7 list 1200..115200; code 0 overflows the 16-bit bit_cyc and sends about 5619 baud
    localparam int unsigned BAUD_TBL [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
    typedef enum logic [2:0] {PMD_PAR_NONE, PMD_PAR_EVEN, PMD_PAR_ODD, PMD_PAR_MARK,
        PMD_PAR_SPACE} pmd_parity_t;
    typedef struct packed {
        logic neg;
        logic [13:0] mag;
        logic over_in;
        logic under_in;
        logic bipolar;
        logic loop_model;
        logic loop_low;
    } pmd_reading_t;
    typedef struct packed {
        logic [3:0] d3;
        logic [3:0] d2;
        logic [3:0] d1;
        logic [3:0] d0;
    } pmd_digits_t;
    typedef struct packed {
        logic [2:0] baud_sel;
        pmd_parity_t parity;
    } pmd_serial_cfg_t;
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic leave_listen;
        logic enter_listen;
    } pmd_cmd_t;
endpackage

/* File: design/pmd_front.sv */
// module: display formatting, indicator dot and serial framing of the panel meter
`timescale 1ns/1ps
module pmd_front
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire pmd_pkg::pmd_reading_t i_reading,
    input wire logic [2:0] i_bright,
    input wire logic [7:0] i_unit_addr,
    input wire logic i_dot_en,
    input wire pmd_pkg::pmd_serial_cfg_t i_ser_cfg,
    input wire pmd_pkg::pmd_cmd_t i_cmd,
    input wire logic i_reply_valid,
    input wire logic [7:0] i_reply_data,
    input wire logic i_rxd,
    output logic o_reply_ready,
    output pmd_pkg::pmd_digits_t o_digits,
    output logic o_overload,
    output logic o_dot,
    output logic o_pwm_on,
    output logic o_listen_only,
    output logic o_cmd_accept,
    output logic o_txd,
    output logic o_tx_oe,
    output logic o_rxd_sync
);
    // -------------------------------------------------------------------------
    // blink timebase
    // -------------------------------------------------------------------------
    logic [31:0] blink_cnt_r;
    logic blink_r;
    wire blink_wrap = (blink_cnt_r == 32'(pmd_pkg::BLINK_HALF_CYC - 1));
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            blink_cnt_r <= 32'h0;
            blink_r <= 1'b0;
        end
        else
        begin
            blink_cnt_r <= blink_wrap ? 32'h0 : blink_cnt_r + 32'h1;
            blink_r <= blink_wrap ? ~blink_r : blink_r;
        end
    end

    // -------------------------------------------------------------------------
    // display formatting
    // -------------------------------------------------------------------------
    function automatic logic [15:0] to_bcd(input logic [13:0] v);
        logic [15:0] b;
        b = 16'h0;
        for (int i = 13; i >= 0; i--)
        begin
            for (int k = 0; k < 4; k++)
            begin
                if (b[k*4 +: 4] > 4'h4)
                begin
                    b[k*4 +: 4] = b[k*4 +: 4] + 4'h3;
                end
            end
            b = {b[14:0], v[i]};
        end
        return b;
    endfunction

    wire [15:0] bcd = to_bcd(i_reading.mag);
    wire ovl_hi = i_reading.over_in || (!i_reading.neg && i_reading.mag > pmd_pkg::MAG_MAX);
    wire ovl_lo = (i_reading.bipolar && i_reading.under_in)
        || (i_reading.loop_model && i_reading.loop_low)
        || (i_reading.neg && i_reading.mag > pmd_pkg::MAG_MAX);
    wire [3:0] bar = ovl_lo ? pmd_pkg::SEG_UNDER : pmd_pkg::SEG_OVER;
    wire [3:0] bar_blink = blink_r ? pmd_pkg::SEG_BLANK : bar;
    wire neg3 = i_reading.neg && (i_reading.mag <= pmd_pkg::MAG_3DIG);
    wire pmd_pkg::pmd_digits_t dig_ovl = {pmd_pkg::SEG_O, pmd_pkg::SEG_L, bar_blink, bar_blink};
    wire pmd_pkg::pmd_digits_t dig_neg3 = {pmd_pkg::SEG_MINUS, bcd[11:0]};
    wire pmd_pkg::pmd_digits_t dig_neg4 = blink_r ? bcd : {pmd_pkg::SEG_MINUS,
        pmd_pkg::SEG_BLANK, pmd_pkg::SEG_BLANK, pmd_pkg::SEG_BLANK};
    wire pmd_pkg::pmd_digits_t dig_nxt = (ovl_hi || ovl_lo) ? dig_ovl
        : !i_reading.neg ? bcd : neg3 ? dig_neg3 : dig_neg4;

    // -------------------------------------------------------------------------
    // brightness
    // -------------------------------------------------------------------------
    logic [2:0] pwm_cnt_r;
    // eight levels, level 7 fully on
    wire pwm_nxt = (pwm_cnt_r <= i_bright);

    // -------------------------------------------------------------------------
    // command acceptance, listen-only, indicator dot
    // -------------------------------------------------------------------------
    logic listen_r;
    logic [31:0] dot_cnt_r;
    wire addr_off = (i_unit_addr >= pmd_pkg::ADDR_OFF_MIN);
    wire addr_hit = addr_off || (i_cmd.addr == i_unit_addr);
    wire cmd_mine = i_cmd.valid && addr_hit;
    // only the leave command acts while listening
    wire accept_nxt = cmd_mine && (!listen_r || i_cmd.leave_listen);
    wire listen_nxt = !cmd_mine ? listen_r
        : listen_r ? !i_cmd.leave_listen : i_cmd.enter_listen;
    wire [31:0] dot_cnt_nxt = cmd_mine ? 32'(pmd_pkg::DOT_CYC)
        : (dot_cnt_r != 32'h0) ? dot_cnt_r - 32'h1 : 32'h0;
    wire dot_nxt = listen_nxt || (i_dot_en && dot_cnt_nxt != 32'h0);

    // -------------------------------------------------------------------------
    // serial transmitter
    // -------------------------------------------------------------------------
    logic [1:0] rx_sync_r;
    logic [15:0] bit_cnt_r;
    logic [3:0] bit_idx_r;
    logic [10:0] sh_r;
    logic busy_r;
    logic ready_r;
    logic txd_r;
    logic oe_r;
    logic [3:0] last_idx_r;
    wire [15:0] bit_cyc = 16'(pmd_pkg::CLK_HZ / pmd_pkg::BAUD_TBL[i_ser_cfg.baud_sel] - 1);
    // parity bit per mode; mark is stop level
    wire par_bit = (i_ser_cfg.parity == pmd_pkg::PMD_PAR_EVEN) ? ^i_reply_data
        : (i_ser_cfg.parity == pmd_pkg::PMD_PAR_ODD) ? ~^i_reply_data
        : (i_ser_cfg.parity == pmd_pkg::PMD_PAR_MARK);
    wire has_par = (i_ser_cfg.parity != pmd_pkg::PMD_PAR_NONE);
    // start, eight data, optional parity, one stop
    wire [10:0] frame = has_par ? {1'b1, par_bit, i_reply_data, 1'b0}
        : {2'b11, i_reply_data, 1'b0};
    // reply bytes only, none while listening
    wire load = !busy_r && i_reply_valid && !listen_r;
    wire bit_end = busy_r && (bit_cnt_r == bit_cyc);

    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rx_sync_r <= 2'b11;
            bit_cnt_r <= 16'h0;
            bit_idx_r <= 4'h0;
            sh_r <= 11'h7ff;
            busy_r <= 1'b0;
            ready_r <= 1'b1;
            txd_r <= 1'b1;
            oe_r <= 1'b0;
            last_idx_r <= 4'h0;
        end
        else
        begin
            rx_sync_r <= {rx_sync_r[0], i_rxd};
            bit_cnt_r <= (load || bit_end) ? 16'h0 : bit_cnt_r + 16'h1;
            if (load)
            begin
                sh_r <= frame;
                last_idx_r <= has_par ? 4'ha : 4'h9;
                bit_idx_r <= 4'h0;
                busy_r <= 1'b1;
                ready_r <= 1'b0;
                txd_r <= 1'b0;
                oe_r <= 1'b1;
            end
            else if (bit_end)
            begin
                busy_r <= (bit_idx_r != last_idx_r);
                ready_r <= (bit_idx_r == last_idx_r);
                oe_r <= (bit_idx_r != last_idx_r);
                bit_idx_r <= bit_idx_r + 4'h1;
                sh_r <= {1'b1, sh_r[10:1]};
                txd_r <= (bit_idx_r == last_idx_r) ? 1'b1 : sh_r[1];
            end
        end
    end

    // -------------------------------------------------------------------------
    // registered outputs
    // -------------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pwm_cnt_r <= 3'h0;
            listen_r <= 1'b0;
            dot_cnt_r <= 32'h0;
            o_digits <= '0;
            o_overload <= 1'b0;
            o_dot <= 1'b0;
            o_pwm_on <= 1'b0;
            o_cmd_accept <= 1'b0;
        end
        else
        begin
            pwm_cnt_r <= pwm_cnt_r + 3'h1;
            listen_r <= listen_nxt;
            dot_cnt_r <= dot_cnt_nxt;
            o_digits <= dig_nxt;
            o_overload <= ovl_hi || ovl_lo;
            o_dot <= dot_nxt;
            o_pwm_on <= pwm_nxt;
            o_cmd_accept <= accept_nxt;
        end
    end

    assign o_listen_only = listen_r;
    // ready is its own flop so the output is not an inverter after busy_r
    assign o_reply_ready = ready_r;
    assign o_txd = txd_r;
    assign o_tx_oe = oe_r;
    assign o_rxd_sync = rx_sync_r[1];
endmodule

/* File: verification/pmd_front_properties.sv */
// checker: port timing relations of the panel meter front
`timescale 1ns/1ps
module pmd_front_properties
(
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire pmd_pkg::pmd_reading_t i_reading,
    input wire logic [7:0] i_unit_addr,
    input wire logic i_dot_en,
    input wire pmd_pkg::pmd_cmd_t i_cmd,
    input wire logic i_reply_valid,
    input wire pmd_pkg::pmd_digits_t o_digits,
    input wire logic o_overload,
    input wire logic o_dot,
    input wire logic o_listen_only,
    input wire logic o_cmd_accept,
    input wire logic o_txd,
    input wire logic o_tx_oe
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_b);
    a_accept_cause: assert property (o_cmd_accept |-> $past(i_cmd.valid))
        else $error("accept without command");
    a_addr_refuse: assert property (i_cmd.valid && i_unit_addr < 8'hf8 &&
        i_cmd.addr != i_unit_addr |=> !o_cmd_accept) else $error("foreign address taken");
    a_noaddr_take: assert property (i_cmd.valid && i_unit_addr >= 8'hf8 &&
        !o_listen_only |=> o_cmd_accept) else $error("command lost with addressing off");
    a_dot_flash: assert property (o_cmd_accept && $past(i_dot_en) |-> o_dot)
        else $error("dot not lit on command");
    a_listen_dot: assert property (o_listen_only && $past(o_listen_only) |-> o_dot)
        else $error("dot dark in listen-only");
    a_listen_mute: assert property ($rose(o_tx_oe) |-> !$past(o_listen_only))
        else $error("reply sent in listen-only");
    a_tx_cause: assert property ($rose(o_tx_oe) |-> $past(i_reply_valid))
        else $error("frame without reply request");
    a_start_low: assert property ($rose(o_tx_oe) |-> !o_txd [*8])
        else $error("start bit missing");
    a_idle_mark: assert property (!o_tx_oe |-> o_txd)
        else $error("line not idle high");
    a_over_show: assert property (i_reading.over_in |=> o_overload &&
        o_digits.d3 == pmd_pkg::SEG_O && o_digits.d2 == pmd_pkg::SEG_L)
        else $error("overload legend missing");
    c_accept: cover property (o_cmd_accept);
    c_listen: cover property ($rose(o_listen_only));
    c_frame: cover property ($rose(o_tx_oe));
endmodule

/* File: verification/pmd_host_model.sv */
// host model: decodes reply frames, keeps its own line idle
`timescale 1ns/1ps
module pmd_host_model
#(
    parameter int BIT_CYC = 868
)
(
    input wire logic i_clk,
    input wire logic i_txd,
    input wire logic i_oe,
    output logic o_rxd,
    output logic [9:0] o_bits,
    output int o_frames
);
    // the host only speaks first through the command port, so this line rests high
    assign o_rxd = 1'b1;
    // mid-bit sampling
    // eight data bits, then parity or stop, then stop or idle
    initial
    begin
        o_bits = '0;
        o_frames = 0;
        forever
        begin
            @(posedge i_clk iff (i_oe && !i_txd));
            repeat (BIT_CYC / 2) @(posedge i_clk);
            for (int k = 0; k < 10; k++)
            begin
                repeat (BIT_CYC) @(posedge i_clk);
                o_bits[k] = i_txd;
            end
            o_frames++;
        end
    end
endmodule

/* File: verification/pmd_front_tb_top.sv */
// testbench: display, indicator, listen-only and serial framing
`timescale 1ns/1ps
module pmd_front_tb_top;
    localparam int BIT_CYC = 868;
    logic i_sys_clk = 1'b0;
    logic i_rst_b = 1'b0;
    pmd_pkg::pmd_reading_t rd = '0;
    logic [2:0] bright = 3'h0;
    logic [7:0] uaddr = 8'h05;
    logic dot_en = 1'b0;
    pmd_pkg::pmd_serial_cfg_t cfg = '{3'h7, pmd_pkg::PMD_PAR_NONE};
    pmd_pkg::pmd_cmd_t cmd = '0;
    logic rv = 1'b0;
    logic [7:0] rdata = 8'ha7;
    logic rxd, rdy, ovl, dot, pwm, lst, acc, txd, oe, rxs;
    pmd_pkg::pmd_digits_t dig;
    logic [9:0] bits;
    int frames;
    int bad_count = 0;
    int checked = 0;
    int n;
    logic par_tbl [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
    pmd_pkg::pmd_reading_t ol_tbl [5] = '{
        '{1'b0, 14'h0064, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0},
        '{1'b1, 14'h0064, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0},
        '{1'b0, 14'h2710, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
        '{1'b1, 14'h2710, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0},
        '{1'b0, 14'h0064, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1}};
    always #5 i_sys_clk = ~i_sys_clk;
    pmd_front i_pmd_front (.i_sys_clk(i_sys_clk), .i_rst_b(i_rst_b), .i_reading(rd),
        .i_bright(bright), .i_unit_addr(uaddr), .i_dot_en(dot_en), .i_ser_cfg(cfg),
        .i_cmd(cmd), .i_reply_valid(rv), .i_reply_data(rdata), .i_rxd(rxd),
        .o_reply_ready(rdy), .o_digits(dig), .o_overload(ovl), .o_dot(dot),
        .o_pwm_on(pwm), .o_listen_only(lst), .o_cmd_accept(acc), .o_txd(txd),
        .o_tx_oe(oe), .o_rxd_sync(rxs));
    pmd_host_model #(.BIT_CYC(BIT_CYC)) i_pmd_host_model (.i_clk(i_sys_clk),
        .i_txd(txd), .i_oe(oe), .o_rxd(rxd), .o_bits(bits), .o_frames(frames));
    task automatic step(int c);
        repeat (c) @(posedge i_sys_clk);
        #1;
    endtask
    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic send_cmd(logic [7:0] a, logic ent, logic lv, logic exp);
        step(1);
        cmd = '{1'b1, a, lv, ent};
        step(1);
        cmd = '0;
        check("accept", 16'(acc), 16'(exp));
    endtask
    task automatic send_byte(int p);
        int f;
        f = frames;
        cfg.parity = pmd_pkg::pmd_parity_t'(p[2:0]);
        check("ready", 16'(rdy), 16'h1);
        rv = 1'b1;
        step(1);
        rv = 1'b0;
        step(12 * BIT_CYC);
        check("frames", 16'(frames - f), 16'h1);
        check("data", 16'(bits[7:0]), 16'(rdata));
        check("tail", 16'(bits[9:8]), 16'({1'b1, par_tbl[p]}));
    endtask
    initial
    begin
        step(16);
        i_rst_b = 1'b1;
        step(2);
        check("rxd sync", 16'(rxs), 16'h1);
        for (int k = 0; k < 5; k++)
        begin
            rd = ol_tbl[k];
            step(2);
            check("ovl", 16'(ovl), 16'h1);
            check("legend", 16'(dig[15:8]), 16'hcd);
        end
        rd = '{1'b1, 14'h03e7, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        step(2);
        check("neg", 16'(dig), 16'hb999);
        rd = '{1'b0, 14'h162e, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
        step(2);
        check("pos", 16'(dig), 16'h5678);
        for (int b = 0; b < 8; b++)
        begin
            bright = 3'(b);
            step(10);
            n = 0;
            for (int c = 0; c < 8; c++)
            begin
                n += int'(pwm);
                step(1);
            end
            check("pwm", 16'(n), 16'(b + 1));
        end
        send_cmd(8'h05, 1'b0, 1'b0, 1'b1);
        check("dot off", 16'(dot), 16'h0);
        send_cmd(8'h06, 1'b0, 1'b0, 1'b0);
        send_cmd(8'h05, 1'b1, 1'b0, 1'b1);
        step(1);
        check("listen", 16'(lst), 16'h1);
        check("dot lit", 16'(dot), 16'h1);
        rv = 1'b1;
        step(1);
        rv = 1'b0;
        step(3);
        check("mute", 16'(oe), 16'h0);
        send_cmd(8'h05, 1'b0, 1'b0, 1'b0);
        send_cmd(8'h05, 1'b0, 1'b1, 1'b1);
        step(1);
        check("listen", 16'(lst), 16'h0);
        dot_en = 1'b1;
        uaddr = 8'hf8;
        send_cmd(8'h33, 1'b0, 1'b0, 1'b1);
        check("dot", 16'(dot), 16'h1);
        step(BIT_CYC * 12);
        // mark entry is what a host picks for two stop bits
        for (int p = 0; p < 5; p++)
            send_byte(p);
        give_verdict();
    end
    initial
    begin
        // tests need about 65000 cycles; stay under the run budget
        repeat (90000) @(posedge i_sys_clk);
        bad_count++;
        give_verdict();
    end
endmodule
bind pmd_front pmd_front_properties i_pmd_front_properties (.i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b), .i_reading(i_reading), .i_unit_addr(i_unit_addr),
    .i_dot_en(i_dot_en), .i_cmd(i_cmd), .i_reply_valid(i_reply_valid),
    .o_digits(o_digits), .o_overload(o_overload), .o_dot(o_dot),
    .o_listen_only(o_listen_only), .o_cmd_accept(o_cmd_accept), .o_txd(o_txd),
    .o_tx_oe(o_tx_oe));
